// [design/mbsi_regs.svh]
/*
 * constants for the memory bus slave front end: field positions, decode
 * values and timing counts.
 * assumes it is included by the package, the design module, the master model and the bench.
 */
`ifndef MBSI_REGS_SVH
`define MBSI_REGS_SVH

// ----------------------------------------------------------------------
// multiplexed line fields
// ----------------------------------------------------------------------
`define MBSI_LINE_W 22
`define MBSI_DATA_W 16
`define MBSI_BAD0_BIT 16
`define MBSI_BAD1_BIT 17
`define MBSI_CSR_LO 5
`define MBSI_CSR_HI 12
`define MBSI_CSR_MATCH_W 8
`define MBSI_PAGE_W 6
`define MBSI_BYTE_W 8

// ----------------------------------------------------------------------
// defaults for decode and timing
// ----------------------------------------------------------------------
`define MBSI_CSR_MATCH_DFLT 8'hFF
`define MBSI_MEM_PAGES_DFLT 6'h20
`define MBSI_ACCESS_NS 60
`define MBSI_CLK_NS 5
`define MBSI_ACCESS_CYC ((`MBSI_ACCESS_NS + `MBSI_CLK_NS - 1) / `MBSI_CLK_NS)
`define MBSI_CNT_W 8
`define MBSI_ZERO_CNT 8'h00
`define MBSI_ONE_CNT 8'h01

`endif

// [design/mbsi_pkg.sv]
/*
 * types for the memory bus slave front end.
 * assumes mbsi_regs.svh is on the include path.
 */
`include "mbsi_regs.svh"

package mbsi_pkg;

    // ------------------------------------------------------------------
    // bus cycle state
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        MBSI_IDLE = 3'b000,
        MBSI_ADDR = 3'b001,
        MBSI_ARB = 3'b010,
        MBSI_TIME = 3'b011,
        MBSI_REPLY = 3'b100,
        MBSI_DONE = 3'b101
    } mbsi_state_t;

    typedef enum logic [1:0] {
        MBSI_SEL_NONE = 2'b00,
        MBSI_SEL_MEM = 2'b01,
        MBSI_SEL_CSR = 2'b10
    } mbsi_sel_t;

    // ------------------------------------------------------------------
    // array access port toward the storage
    // ------------------------------------------------------------------
    typedef struct packed {
        logic rd;
        logic wr;
        logic control_status_register;
        logic [1:0] byte_en;
        logic [`MBSI_LINE_W-1:0] addr;
        logic [`MBSI_DATA_W+1:0] wdata;
    } mbsi_mem_req_t;

    // ------------------------------------------------------------------
    // all module state
    // ------------------------------------------------------------------
    typedef struct packed {
        mbsi_state_t st;
        mbsi_sel_t sel;
        logic [`MBSI_LINE_W-1:0] addr;
        logic [`MBSI_LINE_W-1:0] dout;
        logic rd_req;
        logic wr_req;
        logic byte_wr;
        logic read_done;
        logic reply;
        logic drive;
        logic [`MBSI_CNT_W-1:0] cnt;
        mbsi_mem_req_t mem;
        logic granted;
    } mbsi_state_s_t;

endpackage

// [design/mbsi_slave.sv]
/*
 * bus slave front end of a memory module on an asynchronous backplane
 * bus: decodes the address, arbitrates against refresh, runs a fixed
 * access time, returns the reply handshake.
 * assumes all bus lines are already synchronous to clk and active high;
 * pad inversion and tristating are outside. the storage answers
 * mem_rdata with mem_bad_i within the access time.
 */
`timescale 1ns/1ps
`include "mbsi_regs.svh"

module mbsi_slave import mbsi_pkg::*; #(
    parameter logic [`MBSI_CSR_MATCH_W-1:0] CSR_MATCH = `MBSI_CSR_MATCH_DFLT,
    parameter logic [5:0] MEM_BASE_PAGE = 6'h00,
    parameter logic [5:0] MEM_PAGES = `MBSI_MEM_PAGES_DFLT,
    parameter int ACCESS_CYC = `MBSI_ACCESS_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // backplane lines, sampled
    input wire logic [`MBSI_LINE_W-1:0] mux_data_address_lines_in,
    input wire logic write_byte_select,
    input wire logic io_page_select,
    input wire logic cycle_sync_strobe,
    input wire logic input_strobe,
    input wire logic output_strobe,
    // backplane lines, driven
    output logic [`MBSI_LINE_W-1:0] mux_data_address_lines_out,
    output logic mux_data_address_lines_oe,
    output logic slave_reply,
    // refresh arbitration
    input wire logic refresh_request,
    input wire logic refresh_busy,
    output logic access_busy,
    // storage port
    output mbsi_mem_req_t mem_req,
    input wire logic [`MBSI_DATA_W-1:0] mem_rdata,
    input wire logic mem_bad_i
);

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    // refuse counts the counter cannot hold and ranges past the top page
    if (ACCESS_CYC < 1 || ACCESS_CYC >= (1 << `MBSI_CNT_W)) begin : g_bad_access
        $error("access count out of range");
    end
    if (MEM_PAGES == '0 ||
        int'(MEM_BASE_PAGE) + int'(MEM_PAGES) > (1 << `MBSI_PAGE_W)) begin : g_bad_pages
        $error("memory range out of range");
    end

    localparam logic [`MBSI_CNT_W-1:0] ACC_N = ACCESS_CYC[`MBSI_CNT_W-1:0];

    mbsi_state_s_t s_q, s_d;

    logic io_page_select_internal;
    logic csr_hit, mem_hit;
    logic [`MBSI_PAGE_W-1:0] page;
    logic [`MBSI_DATA_W-1:0] wd;

    assign io_page_select_internal = io_page_select;
    assign page = mux_data_address_lines_in[`MBSI_LINE_W-1:`MBSI_LINE_W-`MBSI_PAGE_W];
    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    assign csr_hit = io_page_select_internal &&
        mux_data_address_lines_in[`MBSI_CSR_HI:`MBSI_CSR_LO] == CSR_MATCH;
    assign mem_hit = !io_page_select_internal && page >= MEM_BASE_PAGE &&
        (page - MEM_BASE_PAGE) < MEM_PAGES;
    assign wd = mux_data_address_lines_in[`MBSI_DATA_W-1:0];

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.mem.rd = 1'b0;
        s_d.mem.wr = 1'b0;
        unique case (s_q.st)
            MBSI_IDLE: begin
                // a fresh cycle needs sync high and our reply low
                if (cycle_sync_strobe && !s_q.reply) begin
                    s_d.addr = mux_data_address_lines_in;
                    s_d.sel = csr_hit ? MBSI_SEL_CSR :
                        (mem_hit ? MBSI_SEL_MEM : MBSI_SEL_NONE);
                    s_d.rd_req = !write_byte_select;
                    s_d.wr_req = write_byte_select;
                    s_d.read_done = 1'b0;
                    s_d.st = MBSI_ADDR;
                end
            end
            MBSI_ADDR: begin
                if (!cycle_sync_strobe) begin
                    s_d.st = MBSI_IDLE;
                end else if (s_q.sel == MBSI_SEL_NONE) begin
                    s_d.st = MBSI_ADDR;
                end else if (input_strobe && !s_q.read_done) begin
                    s_d.rd_req = 1'b1;
                    s_d.wr_req = 1'b0;
                    s_d.st = MBSI_ARB;
                end else if (output_strobe) begin
                    s_d.wr_req = 1'b1;
                    s_d.rd_req = 1'b0;
                    s_d.byte_wr = write_byte_select;
                    s_d.mem.wdata = {^wd[`MBSI_DATA_W-1:`MBSI_BYTE_W],
                        ^wd[`MBSI_BYTE_W-1:0], wd};
                    s_d.st = MBSI_ARB;
                end
            end
            MBSI_ARB: begin
                // refresh keeps the array until it finishes
                if (!refresh_request && !refresh_busy) begin
                    s_d.granted = 1'b1;
                    s_d.cnt = ACC_N;
                    s_d.mem.addr = s_q.addr;
                    s_d.mem.control_status_register = s_q.sel == MBSI_SEL_CSR;
                    s_d.mem.byte_en = !s_q.byte_wr ? 2'b11 :
                        (s_q.addr[0] ? 2'b10 : 2'b01);
                    s_d.mem.rd = s_q.rd_req;
                    s_d.mem.wr = s_q.wr_req;
                    s_d.st = MBSI_TIME;
                end
            end
            MBSI_TIME: begin
                s_d.cnt = s_q.cnt - `MBSI_ONE_CNT;
                if (s_q.cnt == `MBSI_ONE_CNT) begin
                    s_d.granted = 1'b0;
                    s_d.reply = 1'b1;
                    if (s_q.rd_req) begin
                        s_d.dout = {`MBSI_LINE_W{1'b0}};
                        s_d.dout[`MBSI_DATA_W-1:0] = mem_rdata;
                        s_d.dout[`MBSI_BAD0_BIT] = mem_bad_i;
                        s_d.dout[`MBSI_BAD1_BIT] = mem_bad_i;
                        s_d.drive = 1'b1;
                    end
                    s_d.st = MBSI_REPLY;
                end
            end
            MBSI_REPLY: begin
                if (s_q.rd_req ? !input_strobe : !output_strobe) begin
                    s_d.reply = 1'b0;
                    s_d.drive = 1'b0;
                    s_d.read_done = s_q.rd_req;
                    s_d.rd_req = 1'b0;
                    s_d.wr_req = 1'b0;
                    s_d.st = MBSI_DONE;
                end
            end
            MBSI_DONE: begin
                // modify-write may follow the read inside the same sync
                s_d.st = cycle_sync_strobe ? MBSI_ADDR : MBSI_IDLE;
            end
            default: begin
                s_d.st = MBSI_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs straight from state; never a master
    // ------------------------------------------------------------------
    assign mux_data_address_lines_out = s_q.dout;
    assign mux_data_address_lines_oe = s_q.drive;
    assign slave_reply = s_q.reply;
    assign access_busy = s_q.granted;
    assign mem_req = s_q.mem;

    // ------------------------------------------------------------------
    // checks on behaviour
    // ------------------------------------------------------------------
    sequence s_wait_refresh;
        s_q.st == MBSI_ARB && (refresh_request || refresh_busy);
    endsequence

    property p_no_overlap;
        @(posedge clk) disable iff (reset) s_wait_refresh |=> !s_q.granted;
    endproperty
    a_no_overlap: assert property (p_no_overlap) else $error("access overlapped refresh");

    property p_reply_ends_write;
        @(posedge clk) disable iff (reset)
            (s_q.st == MBSI_REPLY && !s_q.rd_req && !output_strobe) |=> !slave_reply;
    endproperty
    a_reply_ends_write: assert property (p_reply_ends_write) else $error("reply stuck");

    property p_read_held;
        @(posedge clk) disable iff (reset)
            (slave_reply && s_q.rd_req && input_strobe) |=> slave_reply && mux_data_address_lines_oe;
    endproperty
    a_read_held: assert property (p_read_held) else $error("read reply dropped early");

    property p_drive_only_read;
        @(posedge clk) disable iff (reset) mux_data_address_lines_oe |-> s_q.rd_req && slave_reply;
    endproperty
    a_drive_only_read: assert property (p_drive_only_read) else $error("stray drive");

    property p_unselected_quiet;
        @(posedge clk) disable iff (reset)
            (s_q.st == MBSI_ADDR && s_q.sel == MBSI_SEL_NONE) |=> !slave_reply && !s_q.granted;
    endproperty
    a_unselected_quiet: assert property (p_unselected_quiet) else $error("answered unselected");

    property p_latch;
        @(posedge clk) disable iff (reset)
            (s_q.st == MBSI_IDLE && cycle_sync_strobe && !slave_reply) |=>
            s_q.addr == $past(mux_data_address_lines_in) && s_q.wr_req == $past(write_byte_select);
    endproperty
    a_latch: assert property (p_latch) else $error("address not latched");

    property p_parity;
        @(posedge clk) disable iff (reset) mem_req.wr |->
            mem_req.wdata[17] == ^mem_req.wdata[15:8] && mem_req.wdata[16] == ^mem_req.wdata[7:0];
    endproperty
    a_parity: assert property (p_parity) else $error("bad parity stored");

    property p_sync_drop;
        @(posedge clk) disable iff (reset)
            (s_q.st == MBSI_ADDR && !cycle_sync_strobe) |=> s_q.st == MBSI_IDLE;
    endproperty
    a_sync_drop: assert property (p_sync_drop) else $error("cycle outlived sync");

    property p_byte_lane;
        @(posedge clk) disable iff (reset) (mem_req.wr && mem_req.byte_en != 2'b11) |->
            mem_req.byte_en == (mem_req.addr[0] ? 2'b10 : 2'b01);
    endproperty
    a_byte_lane: assert property (p_byte_lane) else $error("wrong byte lane");

    property p_csr_decode;
        @(posedge clk) disable iff (reset)
            (s_q.st == MBSI_IDLE && cycle_sync_strobe && !slave_reply && csr_hit) |=>
            s_q.sel == MBSI_SEL_CSR;
    endproperty
    a_csr_decode: assert property (p_csr_decode) else $error("register decode missed");

    // ------------------------------------------------------------------
    // steps of one access: grant, end of timing, answer
    // ------------------------------------------------------------------
    sequence s_grant;
        s_q.st == MBSI_ARB && !refresh_request && !refresh_busy;
    endsequence

    sequence s_timing_end;
        s_q.st == MBSI_TIME && s_q.cnt == `MBSI_ONE_CNT;
    endsequence

    sequence s_read_end;
        s_timing_end ##0 s_q.rd_req;
    endsequence

    property p_grant_starts;
        @(posedge clk) disable iff (reset)
            s_grant |=> access_busy && (mem_req.rd || mem_req.wr) && !slave_reply;
    endproperty
    a_grant_starts: assert property (p_grant_starts) else $error("no access");

    property p_answer;
        @(posedge clk) disable iff (reset) s_timing_end |=> slave_reply && !access_busy;
    endproperty
    a_answer: assert property (p_answer) else $error("no reply after access");

    property p_read_answer;
        @(posedge clk) disable iff (reset)
            s_read_end |=> mux_data_address_lines_oe &&
            mux_data_address_lines_out[`MBSI_DATA_W-1:0] == $past(mem_rdata) &&
            mux_data_address_lines_out[`MBSI_BAD0_BIT] == $past(mem_bad_i) &&
            mux_data_address_lines_out[`MBSI_BAD1_BIT] == $past(mem_bad_i);
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("bad read data");

    property p_read_release;
        @(posedge clk) disable iff (reset)
            (s_q.st == MBSI_REPLY && s_q.rd_req && !input_strobe) |=>
            !slave_reply && !mux_data_address_lines_oe;
    endproperty
    a_read_release: assert property (p_read_release) else $error("read reply held");

    property p_mem_decode;
        @(posedge clk) disable iff (reset)
            (s_q.st == MBSI_IDLE && cycle_sync_strobe && !slave_reply && mem_hit) |=>
            s_q.sel == MBSI_SEL_MEM;
    endproperty
    a_mem_decode: assert property (p_mem_decode) else $error("memory missed");

    property p_write_data;
        @(posedge clk) disable iff (reset)
            (s_q.st == MBSI_ADDR && cycle_sync_strobe && s_q.sel != MBSI_SEL_NONE &&
            !input_strobe && output_strobe) |=>
            s_q.mem.wdata[`MBSI_DATA_W-1:0] == $past(wd);
    endproperty
    a_write_data: assert property (p_write_data) else $error("write data lost");

endmodule

// [dv/mbsi_master.sv]
/*
 * bus master model driving the slave front end: read, write and
 * modify-write cycles with full handshakes.
 * assumes inputs change 1 ns after the rising edge of clk.
 */
`timescale 1ns/1ps
`include "mbsi_regs.svh"

module mbsi_master (
    // clock
    input wire logic clk,
    // lines toward the slave
    output logic [`MBSI_LINE_W-1:0] lines,
    output logic wtbt,
    output logic page,
    output logic sync,
    output logic din,
    output logic dout,
    // answer
    input wire logic reply,
    input wire logic [`MBSI_LINE_W-1:0] rdata
);
    initial begin
        lines = 22'h000000;
        {wtbt, page, sync, din, dout} = 5'h00;
    end

    task automatic step;
        @(posedge clk);
        #1;
    endtask

    // bounded wait, since an unselected slave never answers
    task automatic wait_level(input logic lvl, output int n);
        n = 0;
        while (reply !== lvl && n < 60) begin
            step();
            n++;
        end
    endtask

    task automatic xfer(input logic [21:0] a, input logic pg, rd, wr, bw,
            input logic [15:0] wd, output logic [21:0] rv, output logic got, output int lat);
        int n;
        wait_level(1'b0, n);
        lines = a;
        page = pg;
        wtbt = wr & ~rd;
        sync = 1'b1;
        step();
        lines = ~a;
        page = 1'b0;
        got = 1'b1;
        rv = 22'h000000;
        if (rd) begin
            din = 1'b1;
            wait_level(1'b1, lat);
            got = (reply === 1'b1);
            rv = rdata;
            step();
            din = 1'b0;
            wait_level(1'b0, n);
        end
        if (wr && got) begin
            lines = {6'h00, wd};
            wtbt = bw;
            step();
            dout = 1'b1;
            wait_level(1'b1, lat);
            got = (reply === 1'b1);
            step();
            dout = 1'b0;
            wait_level(1'b0, n);
        end
        step();
        sync = 1'b0;
        wtbt = 1'b0;
        lines = ~lines;
        // the slave must see sync low for an edge, or the next cycle merges
        step();
    endtask
endmodule

// [dv/tb.sv]
/*
 * self-checking bench for the slave front end with a storage model.
 * assumes the master model in mbsi_master.sv and the package.
 */
`timescale 1ns/1ps
`include "mbsi_regs.svh"

module tb import mbsi_pkg::*;;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [21:0] lines_in, lines_out, rv;
    logic wtbt, page, sync, din, dout, oe, reply, abusy, got, last_csr;
    logic rfr_busy = 1'b0;
    logic bad = 1'b0;
    logic [15:0] mem_rdata = 16'h0000;
    logic [15:0] old;
    mbsi_mem_req_t mem_req;
    logic [17:0] store [int];
    logic [15:0] model [int];
    int failures = 0;
    int checks_done = 0;
    int cycles = 0;
    int seed = 45942;
    int lat;
    int busy_run = 0;

    always #2.5 clk = ~clk;

    mbsi_slave i_mbsi_slave (.clk(clk), .reset(reset), .mux_data_address_lines_in(lines_in),
        .write_byte_select(wtbt), .io_page_select(page), .cycle_sync_strobe(sync),
        .input_strobe(din), .output_strobe(dout), .mux_data_address_lines_out(lines_out),
        .mux_data_address_lines_oe(oe), .slave_reply(reply), .refresh_request(rfr_busy),
        .refresh_busy(rfr_busy), .access_busy(abusy), .mem_req(mem_req),
        .mem_rdata(mem_rdata), .mem_bad_i(bad));

    mbsi_master i_mbsi_master (.clk(clk), .lines(lines_in), .wtbt(wtbt), .page(page),
        .sync(sync), .din(din), .dout(dout), .reply(reply), .rdata(lines_out));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude;
        if (failures == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // storage model and monitors
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        cycles++;
        if (cycles > 20000) begin
            failures++;
            conclude();
        end
    end

    always @(posedge clk) begin
        if (reply === 1'b1 && din === 1'b1) check(oe, 1'b1);
        if (reply === 1'b1 && dout === 1'b1) check(oe, 1'b0);
        if (abusy === 1'b1) check(rfr_busy, 1'b0);
        if (abusy === 1'b1) begin
            busy_run++;
        end else if (busy_run != 0) begin
            check(busy_run, `MBSI_ACCESS_CYC);
            busy_run = 0;
        end
        if (mem_req.rd === 1'b1) begin
            mem_rdata <= store.exists(mem_req.addr[21:1]) ? store[mem_req.addr[21:1]][15:0] : 16'h0000;
        end
        if (mem_req.wr === 1'b1) begin
            last_csr = mem_req.control_status_register;
            check(mem_req.wdata[17:16], {^mem_req.wdata[15:8], ^mem_req.wdata[7:0]});
            if (mem_req.control_status_register !== 1'b1) begin
                old = store.exists(mem_req.addr[21:1]) ? store[mem_req.addr[21:1]][15:0] : 16'h0000;
                if (mem_req.byte_en[0]) old[7:0] = mem_req.wdata[7:0];
                if (mem_req.byte_en[1]) old[15:8] = mem_req.wdata[15:8];
                store[mem_req.addr[21:1]] = {2'b00, old};
            end
        end
    end

    // one bus cycle, checked against the word model
    task automatic run(input logic [21:0] a, input logic pg, rd, wr, bw, input logic [15:0] wd);
        logic [15:0] w;
        w = model.exists(a[21:1]) ? model[a[21:1]] : 16'h0000;
        i_mbsi_master.xfer(a, pg, rd, wr, bw, wd, rv, got, lat);
        check(reply, 1'b0);
        check(oe, 1'b0);
        if (rd && got && !pg) begin
            check(rv[15:0], w);
            check(rv[17:16], {2{bad}});
        end
        if (wr && got && !pg) begin
            if (!bw || a[0]) w[15:8] = wd[15:8];
            if (!bw || !a[0]) w[7:0] = wd[7:0];
            model[a[21:1]] = w;
        end
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [21:0] a;
        repeat (8) @(posedge clk);
        #1;
        reset = 1'b0;
        for (int i = 0; i < 12; i++) begin
            a = {1'b0, 5'($random(seed)), 16'($random(seed))};
            run(a, 1'b0, 1'b0, 1'b1, i[0], 16'($random(seed)));
            check(got, 1'b1);
            check(last_csr, 1'b0);
            check(32'(lat >= `MBSI_ACCESS_CYC), 1);
            bad = (i == 5);
            if (i == 7) begin
                rfr_busy = 1'b1;
                fork
                    begin
                        repeat (30) @(posedge clk);
                        #1;
                        rfr_busy = 1'b0;
                    end
                join_none
            end
            run(a, 1'b0, 1'b1, i % 3 == 2, i[1], 16'($random(seed)));
            check(got, 1'b1);
            if (i == 7) check(32'(lat >= 28), 1);
            bad = 1'b0;
        end
        run({6'h3F, 16'h1234}, 1'b0, 1'b1, 1'b0, 1'b0, 16'h0000);
        check(got, 1'b0);
        run({9'h1FF, 8'h00, 5'h00}, 1'b1, 1'b0, 1'b1, 1'b0, 16'hA5A5);
        check(got, 1'b0);
        run({9'h1FF, 8'hFF, 5'h00}, 1'b1, 1'b0, 1'b1, 1'b0, 16'h5A3C);
        check(got, 1'b1);
        check(last_csr, 1'b1);
        run({9'h1FF, 8'hFF, 5'h00}, 1'b1, 1'b1, 1'b0, 1'b0, 16'h0000);
        check(got, 1'b1);
        conclude();
    end
endmodule
